/* File: verilog/dma_pkg.sv */
// constants shared by the four-channel dma controller and its testbench
// assumes a single 50 mhz clock and a synchronous active-high reset
package dma_pkg;
	localparam int          NCH          = 4;
	localparam int          CLK_NS       = 20;
	localparam logic [1:0]  MODE_VERIFY  = 2'h0;
	localparam logic [1:0]  MODE_WRITE   = 2'h1;
	localparam logic [1:0]  MODE_READ    = 2'h2;
	localparam int          MS_AL        = 7;
	localparam int          MS_TCS       = 6;
	localparam int          MS_EW        = 5;
	localparam int          MS_RP        = 4;
	localparam int          ST_UP        = 4;
	localparam int          SEL_HI       = 3;
	localparam logic [2:0]  SEL_MODESET  = 3'h0;
	localparam logic [7:0]  MODESET_INIT = 8'h00;
	localparam logic [15:0] REG_INIT     = 16'h0000;
	localparam logic [13:0] COUNT_ZERO   = 14'h0000;
	localparam logic [13:0] COUNT_STEP   = 14'h0001;
	localparam logic [15:0] ADDR_STEP    = 16'h0001;
	localparam logic [6:0]  MARK_LAST    = 7'h7f;
	localparam logic [6:0]  MARK_INIT    = 7'h00;
	localparam logic [6:0]  MARK_STEP    = 7'h01;
	localparam logic [1:0]  CH_AUTO_DST  = 2'h2;
	localparam logic [1:0]  CH_AUTO_SRC  = 2'h3;
	localparam logic [1:0]  CH_STEP      = 2'h1;
	localparam logic [1:0]  CH_FIRST     = 2'h0;
	typedef enum logic [2:0] {
		st_idle, st_s0, st_s1, st_s2, st_s3, st_sw, st_s4
	} dma_state_t;
endpackage

/* File: verilog/two_entry_buffer.sv */
// two-entry buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] slot0;
	logic [WIDTH-1:0] slot1;
	logic [1:0]       fill;
	logic [WIDTH-1:0] next_slot0;
	logic [WIDTH-1:0] next_slot1;
	logic [1:0]       next_fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != 2'h2);
	assign out_valid = (fill != 2'h0);
	assign out_data  = slot0;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_fill  = fill;
		if (pop) begin
			next_slot0 = slot1;
		end
		if (push) begin
			if (fill == 2'h0 || (fill == 2'h1 && pop)) begin
				next_slot0 = in_data;
			end else begin
				next_slot1 = in_data;
			end
		end
		if (push && !pop) begin
			next_fill = fill + 2'h1;
		end else if (pop && !push) begin
			next_fill = fill - 2'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			slot0 <= '0;
			slot1 <= '0;
			fill  <= 2'h0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			fill  <= next_fill;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/dma_controller.sv */
// four-channel dma controller: cpu register slave plus bus-master engine
// assumes inputs synchronous to mclk except channel_request and ready
`timescale 1ns/1ns
`default_nettype none
module dma_controller (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [3:0] channel_request,
	output logic      [3:0] channel_grant_n,
	output logic            bus_request_out,
	input  wire logic       bus_grant_in,
	input  wire logic       ready,
	input  wire logic       chip_select_n,
	input  wire logic       io_read_strobe_n_in,
	output logic            io_read_strobe_n_out,
	output logic            io_read_strobe_oe,
	input  wire logic       io_write_strobe_n_in,
	output logic            io_write_strobe_n_out,
	output logic            io_write_strobe_oe,
	output logic            mem_read_strobe_n,
	output logic            mem_write_strobe_n,
	output logic            mem_strobe_oe,
	input  wire logic [3:0] addr_low_in,
	output logic      [3:0] addr_low_out,
	output logic            addr_low_oe,
	output logic      [3:0] addr_mid_out,
	output logic            addr_mid_oe,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            upper_addr_latch_strobe,
	output logic            addr_drive_enable,
	output logic            count_done_pulse,
	output logic            modulo_128_pulse
);
	localparam int N = dma_pkg::NCH;

	dma_pkg::dma_state_t state, next_state;
	logic [15:0] addr [N], next_addr [N];
	logic [15:0] count [N], next_count [N];
	logic [6:0]  mark [N], next_mark [N];
	logic [7:0]  modeset, next_modeset;
	logic [3:0]  tc_flag, next_tc_flag;
	logic        upd_flag, next_upd_flag;
	logic        first_last, next_first_last;
	logic [1:0]  chan, next_chan;
	logic [1:0]  rot_base, next_rot_base;
	logic [3:0]  req_meta, req_sync;
	logic        rdy_meta, rdy_sync;
	logic        rd_prev, wr_prev;
	logic [3:0]  pending;
	logic [1:0]  pick;
	logic        any_pend;
	logic        slave, own, rd_go, wr_go, rd_end;
	logic [7:0]  rd_byte;
	logic        buf_in_ready, buf_out_valid;
	logic [7:0]  buf_out_data;
	logic [1:0]  cur_mode;
	logic        cur_last, in_data_phase, in_write_phase;

	// plain two-flop synchronisers; the first stage feeds nothing else
	always_ff @(posedge mclk) begin
		if (reset) begin
			req_meta <= 4'h0;
			req_sync <= 4'h0;
			rdy_meta <= 1'b0;
			rdy_sync <= 1'b0;
			rd_prev  <= 1'b1;
			wr_prev  <= 1'b1;
		end else begin
			req_meta <= channel_request;
			req_sync <= req_meta;
			rdy_meta <= ready;
			rdy_sync <= rdy_meta;
			rd_prev  <= io_read_strobe_n_in;
			wr_prev  <= io_write_strobe_n_in;
		end
	end

	assign pending  = req_sync & modeset[3:0];
	assign any_pend = |pending;

	// rotating mode scans from the channel after the last one served
	always_comb begin
		logic [1:0] idx;
		logic       found;
		idx   = 2'h0;
		found = 1'b0;
		pick  = dma_pkg::CH_FIRST;
		for (int k = 0; k < N; k++) begin
			idx = modeset[dma_pkg::MS_RP] ? rot_base + 2'(k) : 2'(k);
			if (!found && pending[idx]) begin
				pick  = idx;
				found = 1'b1;
			end
		end
	end

	// slave only in idle, or in s0 before the grant arrives; cs is moot as master
	assign slave  = (state == dma_pkg::st_idle)
		|| (state == dma_pkg::st_s0 && !bus_grant_in);
	// s0 with grant is neither side: the channel is only picked on its edge
	assign own    = bus_grant_in && !slave
		&& state != dma_pkg::st_s0;
	assign rd_go  = slave && !chip_select_n && rd_prev
		&& !io_read_strobe_n_in;
	assign wr_go  = slave && !chip_select_n && wr_prev
		&& !io_write_strobe_n_in;
	assign rd_end = slave && !rd_prev && io_read_strobe_n_in;

	always_comb begin
		if (addr_low_in[dma_pkg::SEL_HI]) begin
			rd_byte = {3'h0, upd_flag, tc_flag};
		end else if (addr_low_in[0]) begin
			rd_byte = first_last ? count[addr_low_in[2:1]][15:8]
				: count[addr_low_in[2:1]][7:0];
		end else begin
			rd_byte = first_last ? addr[addr_low_in[2:1]][15:8]
				: addr[addr_low_in[2:1]][7:0];
		end
	end

	// read data waits here if the cpu holds off; a full buffer
	// refuses the read and the first/last toggle does not advance
	two_entry_buffer #(.WIDTH(8)) read_buf (
		.mclk      (mclk),
		.reset     (reset),
		.in_valid  (rd_go),
		.in_ready  (buf_in_ready),
		.in_data   (rd_byte),
		.out_valid (buf_out_valid),
		.out_ready (rd_end),
		.out_data  (buf_out_data)
	);

	assign cur_mode = count[chan][15:14];
	assign cur_last = (count[chan][13:0] == dma_pkg::COUNT_ZERO);

	always_comb begin
		next_state      = state;
		next_addr       = addr;
		next_count      = count;
		next_mark       = mark;
		next_modeset    = modeset;
		next_tc_flag    = tc_flag;
		next_upd_flag   = upd_flag;
		next_first_last = first_last;
		next_chan       = chan;
		next_rot_base   = rot_base;
		if (wr_go) begin
			if (addr_low_in[dma_pkg::SEL_HI]) begin
				if (addr_low_in[2:0] == dma_pkg::SEL_MODESET) begin
					next_modeset    = data_in;
					next_first_last = 1'b0;
				end
			end else begin
				next_first_last = !first_last;
				if (addr_low_in[0] && first_last) begin
					next_count[addr_low_in[2:1]][15:8] = data_in;
				end else if (addr_low_in[0]) begin
					next_count[addr_low_in[2:1]][7:0] = data_in;
				end else if (first_last) begin
					next_addr[addr_low_in[2:1]][15:8] = data_in;
				end else begin
					next_addr[addr_low_in[2:1]][7:0] = data_in;
				end
			end
		end
		if (rd_go && buf_in_ready) begin
			if (addr_low_in[dma_pkg::SEL_HI]) begin
				next_tc_flag  = 4'h0;
				next_upd_flag = 1'b0;
			end else begin
				next_first_last = !first_last;
			end
		end
		case (state)
			dma_pkg::st_idle: begin
				if (any_pend) begin
					next_state = dma_pkg::st_s0;
				end
			end
			dma_pkg::st_s0: begin
				if (!any_pend) begin
					next_state = dma_pkg::st_idle;
				end else if (bus_grant_in) begin
					next_chan  = pick;
					next_state = dma_pkg::st_s1;
				end
			end
			dma_pkg::st_s1: begin
				next_state = dma_pkg::st_s2;
			end
			dma_pkg::st_s2: begin
				next_state = dma_pkg::st_s3;
			end
			dma_pkg::st_s3, dma_pkg::st_sw: begin
				// verify moves no memory, so waits would only stall
				if (rdy_sync || cur_mode == dma_pkg::MODE_VERIFY) begin
					next_state = dma_pkg::st_s4;
					next_addr[chan]  = addr[chan] + dma_pkg::ADDR_STEP;
					next_count[chan][13:0] = count[chan][13:0]
						- dma_pkg::COUNT_STEP;
					next_mark[chan]  = mark[chan] + dma_pkg::MARK_STEP;
					next_rot_base    = chan + dma_pkg::CH_STEP;
					if (cur_last) begin
						next_tc_flag[chan] = 1'b1;
						if (modeset[dma_pkg::MS_TCS]) begin
							next_modeset[chan] = 1'b0;
						end
						if (modeset[dma_pkg::MS_AL]
							&& chan == dma_pkg::CH_AUTO_DST) begin
							next_addr[chan]  = addr[dma_pkg::CH_AUTO_SRC];
							next_count[chan] = count[dma_pkg::CH_AUTO_SRC];
							next_upd_flag    = 1'b1;
						end
					end
				end else begin
					next_state = dma_pkg::st_sw;
				end
			end
			dma_pkg::st_s4: begin
				if (any_pend && bus_grant_in) begin
					next_chan  = pick;
					next_state = dma_pkg::st_s1;
				end else begin
					next_state = dma_pkg::st_idle;
				end
			end
			default: begin
				next_state = dma_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state      <= dma_pkg::st_idle;
			modeset    <= dma_pkg::MODESET_INIT;
			tc_flag    <= 4'h0;
			upd_flag   <= 1'b0;
			first_last <= 1'b0;
			chan       <= dma_pkg::CH_FIRST;
			rot_base   <= dma_pkg::CH_FIRST;
			for (int c = 0; c < N; c++) begin
				addr[c]  <= dma_pkg::REG_INIT;
				count[c] <= dma_pkg::REG_INIT;
				mark[c]  <= dma_pkg::MARK_INIT;
			end
		end else begin
			state      <= next_state;
			modeset    <= next_modeset;
			tc_flag    <= next_tc_flag;
			upd_flag   <= next_upd_flag;
			first_last <= next_first_last;
			chan       <= next_chan;
			rot_base   <= next_rot_base;
			addr       <= next_addr;
			count      <= next_count;
			mark       <= next_mark;
		end
	end

	assign in_data_phase  = own && (state == dma_pkg::st_s2
		|| state == dma_pkg::st_s3 || state == dma_pkg::st_sw);
	assign in_write_phase = own && (state == dma_pkg::st_s3
		|| state == dma_pkg::st_sw
		|| (state == dma_pkg::st_s2 && modeset[dma_pkg::MS_EW]));

	assign bus_request_out = (state != dma_pkg::st_idle);

	always_comb begin
		channel_grant_n = 4'hf;
		if (own && state != dma_pkg::st_s1) begin
			channel_grant_n[chan] = 1'b0;
		end
	end

	assign addr_drive_enable       = own;
	assign upper_addr_latch_strobe = own && (state == dma_pkg::st_s1);
	assign addr_low_out  = addr[chan][3:0];
	assign addr_low_oe   = own;
	assign addr_mid_out  = addr[chan][7:4];
	assign addr_mid_oe   = own;
	assign data_out      = own ? addr[chan][15:8] : buf_out_data;
	assign data_oe       = upper_addr_latch_strobe
		|| (slave && buf_out_valid && !chip_select_n
		&& !io_read_strobe_n_in);
	assign mem_strobe_oe      = own;
	assign io_read_strobe_oe  = own;
	assign io_write_strobe_oe = own;
	assign mem_read_strobe_n  = !(in_data_phase
		&& cur_mode == dma_pkg::MODE_READ);
	assign io_write_strobe_n_out = !(in_write_phase
		&& cur_mode == dma_pkg::MODE_READ);
	assign io_read_strobe_n_out  = !(in_data_phase
		&& cur_mode == dma_pkg::MODE_WRITE);
	assign mem_write_strobe_n = !(in_write_phase
		&& cur_mode == dma_pkg::MODE_WRITE);
	assign count_done_pulse = own && state == dma_pkg::st_s3
		&& cur_last;
	assign modulo_128_pulse = own && state == dma_pkg::st_s3
		&& mark[chan] == dma_pkg::MARK_LAST;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_request_follows_pend: assert property (
		state == dma_pkg::st_idle && any_pend |=> bus_request_out)
		else $error("bus request missing after pending channel");
	a_grant_needs_bus: assert property (
		channel_grant_n != 4'hf |-> bus_grant_in
			&& $onehot(~channel_grant_n))
		else $error("channel grant without bus or not one-hot");
	a_latch_with_upper: assert property (
		upper_addr_latch_strobe |-> data_oe && addr_drive_enable
			&& data_out == addr[chan][15:8])
		else $error("latch strobe without upper address byte");
	a_wait_holds_cycle: assert property (
		state == dma_pkg::st_s3 && own && !rdy_sync
			&& cur_mode != dma_pkg::MODE_VERIFY
			|=> state == dma_pkg::st_sw
				&& !(mem_read_strobe_n && mem_write_strobe_n))
		else $error("ready low did not stretch the cycle");
	a_four_states_min: assert property (
		state == dma_pkg::st_s1 && own
			|=> state == dma_pkg::st_s2 ##1 state == dma_pkg::st_s3)
		else $error("transfer shorter than four states");
	a_done_wraps_count: assert property (
		count_done_pulse && rdy_sync |=>
			count[$past(chan)][13:0] == 14'h3fff)
		else $error("count did not wrap on done pulse");
	a_bus_released_off: assert property (
		!bus_grant_in |-> !addr_low_oe && !mem_strobe_oe
			&& !addr_drive_enable && channel_grant_n == 4'hf)
		else $error("bus driven without grant");
	a_reset_clears_mask: assert property (
		disable iff (1'b0) reset |=> modeset == dma_pkg::MODESET_INIT
			&& !bus_request_out)
		else $error("reset left channels enabled");
	a_verify_no_strobe: assert property (
		cur_mode == dma_pkg::MODE_VERIFY |-> mem_read_strobe_n
			&& mem_write_strobe_n)
		else $error("memory strobe in verify mode");
	a_cs_ignored_master: assert property (
		own && !cur_last && !chip_select_n && !io_write_strobe_n_in
			|=> modeset == $past(modeset))
		else $error("register access while bus master");

	c_full_transfer: cover property (
		state == dma_pkg::st_s1 ##3 state == dma_pkg::st_s4);
	c_wait_state: cover property (state == dma_pkg::st_sw);
	c_count_done: cover property (count_done_pulse);
	c_mark_pulse: cover property (modulo_128_pulse);
endmodule
`default_nettype wire

/* File: test/hold_partner.sv */
// partner model: cpu hold handshake and a slow memory on the ready line
// assumes the controller's request and strobes change on the same mclk
`timescale 1ns/1ns
`default_nettype none
module hold_partner (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic bus_request_out,
	input  wire logic mem_read_strobe_n,
	input  wire logic mem_write_strobe_n,
	input  wire logic slow,
	output logic      bus_grant_in,
	output logic      ready
);
	logic [1:0] held;
	logic [2:0] waited;
	// slow memory keeps ready low until four strobe cycles have passed
	assign ready = !slow || waited == 3'h4;
	always @(posedge mclk) begin
		if (reset || !bus_request_out) begin
			held <= 2'h0;
			bus_grant_in <= 1'b0;
		end else begin
			// a cpu finishes its instruction before handing the bus over
			if (held != 2'h2)
				held <= held + 2'h1;
			bus_grant_in <= held == 2'h2;
		end
		if (reset || !bus_request_out || !slow)
			waited <= 3'h0;
		else if (!(mem_read_strobe_n && mem_write_strobe_n) && waited != 3'h4)
			waited <= waited + 3'h1;
	end
endmodule
`default_nettype wire

/* File: test/dma_controller_tb_top.sv */
// self-checking bench for the four-channel dma controller
// assumes the design files and hold_partner are compiled before it
`timescale 1ns/1ns
`default_nettype none
module dma_controller_tb_top;
	logic       mclk, reset, bus_grant_in, ready, chip_select_n, slow;
	logic       io_read_strobe_n_in, io_write_strobe_n_in;
	logic       io_read_strobe_n_out, io_read_strobe_oe;
	logic       io_write_strobe_n_out, io_write_strobe_oe;
	logic       mem_read_strobe_n, mem_write_strobe_n, mem_strobe_oe;
	logic       bus_request_out, addr_low_oe, addr_mid_oe, data_oe;
	logic       upper_addr_latch_strobe, addr_drive_enable;
	logic       count_done_pulse, modulo_128_pulse;
	logic [3:0] channel_request, channel_grant_n, addr_low_in;
	logic [3:0] addr_low_out, addr_mid_out;
	logic [7:0] data_in, data_out;
	int         error_cnt, comparisons, cycles;

	dma_controller i_dma_controller (.mclk(mclk), .reset(reset),
		.channel_request(channel_request), .channel_grant_n(channel_grant_n),
		.bus_request_out(bus_request_out), .bus_grant_in(bus_grant_in),
		.ready(ready), .chip_select_n(chip_select_n),
		.io_read_strobe_n_in(io_read_strobe_n_in),
		.io_read_strobe_n_out(io_read_strobe_n_out),
		.io_read_strobe_oe(io_read_strobe_oe),
		.io_write_strobe_n_in(io_write_strobe_n_in),
		.io_write_strobe_n_out(io_write_strobe_n_out),
		.io_write_strobe_oe(io_write_strobe_oe),
		.mem_read_strobe_n(mem_read_strobe_n),
		.mem_write_strobe_n(mem_write_strobe_n), .mem_strobe_oe(mem_strobe_oe),
		.addr_low_in(addr_low_in), .addr_low_out(addr_low_out),
		.addr_low_oe(addr_low_oe), .addr_mid_out(addr_mid_out),
		.addr_mid_oe(addr_mid_oe), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .upper_addr_latch_strobe(upper_addr_latch_strobe),
		.addr_drive_enable(addr_drive_enable),
		.count_done_pulse(count_done_pulse), .modulo_128_pulse(modulo_128_pulse));
	hold_partner i_hold_partner (.mclk(mclk), .reset(reset),
		.bus_request_out(bus_request_out), .mem_read_strobe_n(mem_read_strobe_n),
		.mem_write_strobe_n(mem_write_strobe_n), .slow(slow),
		.bus_grant_in(bus_grant_in), .ready(ready));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// cut a hang short well past the thousand or so cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		chip_select_n <= 1'b0;
		io_write_strobe_n_in <= 1'b0;
		addr_low_in <= a;
		data_in <= d;
		@(posedge mclk);
		chip_select_n <= 1'b1;
		io_write_strobe_n_in <= 1'b1;
		@(posedge mclk);
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		chip_select_n <= 1'b0;
		io_read_strobe_n_in <= 1'b0;
		addr_low_in <= a;
		@(posedge mclk);
		@(negedge mclk);
		check({data_oe, data_out}, {1'b1, exp});
		@(posedge mclk);
		chip_select_n <= 1'b1;
		io_read_strobe_n_in <= 1'b1;
		@(posedge mclk);
	endtask

	task automatic setup(input logic [1:0] ch, input logic [15:0] a,
		input logic [15:0] cnt);
		reg_wr(4'h8, 8'h00);
		reg_wr({1'b0, ch, 1'b0}, a[7:0]);
		reg_wr({1'b0, ch, 1'b0}, a[15:8]);
		reg_wr({1'b0, ch, 1'b1}, cnt[7:0]);
		reg_wr({1'b0, ch, 1'b1}, cnt[15:8]);
	endtask

	task automatic request(input logic [3:0] r, input logic s);
		@(posedge mclk);
		channel_request <= r;
		slow <= s;
	endtask

	// one byte from S1 to S4; len 0 means wait states are expected
	task automatic xfer(input logic [1:0] ch, input logic [1:0] md,
		input logic [15:0] a, input logic [1:0] ends, input int len);
		int n;
		logic [1:0] p;
		logic [3:0] g;
		n = 0;
		g = ~(4'h1 << ch);
		p = md == dma_pkg::MODE_READ ? 2'b01 :
			md == dma_pkg::MODE_WRITE ? 2'b10 : 2'b11;
		do begin
			@(negedge mclk);
			n++;
		end while (upper_addr_latch_strobe !== 1'b1 && n < 80);
		check(n < 80, 1'b1);
		check({data_out, addr_mid_out, addr_low_out}, a);
		check({data_oe, addr_low_oe, addr_drive_enable}, 3'h7);
		check({addr_mid_oe, mem_strobe_oe, io_read_strobe_oe,
			io_write_strobe_oe}, 4'hf);
		@(negedge mclk);
		check(channel_grant_n, g);
		check({mem_read_strobe_n, io_read_strobe_n_out}, p);
		@(negedge mclk);
		check({io_write_strobe_n_out, mem_write_strobe_n}, p);
		check({count_done_pulse, modulo_128_pulse}, ends);
		n = 3;
		do begin
			@(negedge mclk);
			n++;
		end while (!(mem_read_strobe_n && mem_write_strobe_n &&
			io_read_strobe_n_out && io_write_strobe_n_out) && n < 40);
		check(channel_grant_n, g);
		if (len == 0)
			check(n > 4, 1'b1);
		else
			check(n, len);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (bus_request_out !== 1'b0 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		check(bus_request_out, 1'b0);
	endtask

	task automatic check_idle();
		check({bus_request_out, channel_grant_n, mem_read_strobe_n,
			mem_write_strobe_n}, 7'h3f);
		check({data_oe, addr_low_oe, addr_mid_oe, mem_strobe_oe,
			io_read_strobe_oe, io_write_strobe_oe, addr_drive_enable,
			upper_addr_latch_strobe}, 8'h00);
	endtask

	task automatic s_read_pair();
		setup(2'h0, 16'h12a5, {dma_pkg::MODE_READ, 14'h0001});
		reg_wr(4'h8, 8'h41);
		request(4'h1, 1'b0);
		xfer(2'h0, dma_pkg::MODE_READ, 16'h12a5, 2'b00, 4);
		xfer(2'h0, dma_pkg::MODE_READ, 16'h12a6, 2'b10, 4);
		request(4'h0, 1'b0);
		wait_idle();
		reg_wr(4'h8, 8'h00);
		reg_rd(4'h0, 8'ha7);
		reg_rd(4'h0, 8'h12);
		reg_rd(4'h1, 8'hff);
		reg_rd(4'h1, 8'hbf);
		reg_rd(4'h8, 8'h01);
		reg_rd(4'h8, 8'h00);
	endtask

	task automatic s_priority();
		setup(2'h2, 16'h2000, {dma_pkg::MODE_READ, 14'h0000});
		setup(2'h1, 16'h1000, {dma_pkg::MODE_READ, 14'h0000});
		reg_wr(4'h8, 8'h46);
		request(4'h6, 1'b0);
		xfer(2'h1, dma_pkg::MODE_READ, 16'h1000, 2'b10, 4);
		xfer(2'h2, dma_pkg::MODE_READ, 16'h2000, 2'b10, 4);
		request(4'h0, 1'b0);
		wait_idle();
		reg_rd(4'h8, 8'h06);
		setup(2'h0, 16'h0100, {dma_pkg::MODE_VERIFY, 14'h0003});
		setup(2'h1, 16'h0200, {dma_pkg::MODE_VERIFY, 14'h0003});
		reg_wr(4'h8, 8'h13);
		request(4'h3, 1'b0);
		xfer(2'h0, dma_pkg::MODE_VERIFY, 16'h0100, 2'b00, 4);
		xfer(2'h1, dma_pkg::MODE_VERIFY, 16'h0200, 2'b00, 4);
		xfer(2'h0, dma_pkg::MODE_VERIFY, 16'h0101, 2'b00, 4);
		request(4'h0, 1'b0);
		wait_idle();
	endtask

	task automatic s_slow_and_mark();
		setup(2'h1, 16'h0ff0, {dma_pkg::MODE_WRITE, 14'h0000});
		reg_wr(4'h8, 8'h42);
		request(4'h2, 1'b1);
		xfer(2'h1, dma_pkg::MODE_WRITE, 16'h0ff0, 2'b10, 0);
		request(4'h0, 1'b0);
		wait_idle();
		// ready stays low: verify bytes must still take four states
		setup(2'h3, 16'h3ff0, {dma_pkg::MODE_VERIFY, 14'h007f});
		reg_wr(4'h8, 8'h48);
		request(4'h8, 1'b1);
		for (int i = 0; i < 128; i++)
			xfer(2'h3, dma_pkg::MODE_VERIFY, 16'h3ff0 + 16'(i), {2{i == 127}}, 4);
		request(4'h0, 1'b0);
		wait_idle();
		reg_rd(4'h8, 8'h0a);
	endtask

	task automatic s_reset_mid();
		int n;
		n = 0;
		setup(2'h0, 16'h0000, {dma_pkg::MODE_READ, 14'h0010});
		reg_wr(4'h8, 8'h01);
		request(4'h1, 1'b0);
		while (upper_addr_latch_strobe !== 1'b1 && n < 80) begin
			@(negedge mclk);
			n++;
		end
		check(n < 80, 1'b1);
		// a cpu write of zero enables while we own the bus must be ignored
		@(posedge mclk);
		chip_select_n <= 1'b0;
		io_write_strobe_n_in <= 1'b0;
		addr_low_in <= 4'h8;
		data_in <= 8'h00;
		repeat (2) @(posedge mclk);
		chip_select_n <= 1'b1;
		io_write_strobe_n_in <= 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (upper_addr_latch_strobe !== 1'b1 && n < 20);
		check(n < 20, 1'b1);
		@(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		@(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		check_idle();
		repeat (10) @(negedge mclk);
		check(bus_request_out, 1'b0);
		request(4'h0, 1'b0);
	endtask

	// read byte waits in the design's buffer and stands until the strobe rises
	task automatic s_buffer();
		reg_wr(4'h2, 8'h5a);
		reg_wr(4'h2, 8'hc3);
		reg_wr(4'h8, 8'h00);
		@(posedge mclk);
		chip_select_n <= 1'b0;
		io_read_strobe_n_in <= 1'b0;
		addr_low_in <= 4'h2;
		repeat (2) @(negedge mclk);
		check({data_oe, data_out}, {1'b1, 8'h5a});
		@(negedge mclk);
		check({data_oe, data_out}, {1'b1, 8'h5a});
		@(posedge mclk);
		chip_select_n <= 1'b1;
		io_read_strobe_n_in <= 1'b1;
		@(negedge mclk);
		check(data_oe, 1'b0);
		reg_rd(4'h2, 8'hc3);
		reg_rd(4'h8, 8'h00);
	endtask

	initial begin
		{reset, chip_select_n, io_read_strobe_n_in, io_write_strobe_n_in} = 4'hf;
		slow = 1'b0;
		{channel_request, addr_low_in, data_in} = 16'h0000;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		check_idle();
		request(4'hf, 1'b0);
		repeat (10) @(negedge mclk);
		check(bus_request_out, 1'b0);
		request(4'h0, 1'b0);
		reg_rd(4'h8, 8'h00);
		s_read_pair();
		s_priority();
		s_slow_and_mark();
		s_reset_mid();
		s_buffer();
		wrap_up();
	end
endmodule
`default_nettype wire
